// *** src/sleep_keep_defines.vh ***
// Register map, field positions and reset values of the sleep keep block.
// Assumes byte-wide registers reached over the two-wire control port.
`ifndef SLEEP_KEEP_DEFINES_VH
`define SLEEP_KEEP_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_KEEP_FULL_LOAD 8'h41
`define OFS_RETENTION 8'h42
`define OFS_DEV_CTRL 8'h50
`define OFS_REG_ENABLE 8'h51
`define OFS_REG_ASSIGN 8'h52
`define OFS_REG_OVR_LO 8'h53
`define OFS_REG_OVR_HI 8'h54
`define OFS_CONV_CFG 8'h55
`define OFS_CONV_OVR 8'h56
`define OFS_STATUS 8'h57

// ----------------------------------------------------------------------
// Retention register fields
// ----------------------------------------------------------------------
`define RET_CONV_LSB 0
`define RET_RESERVED 3
`define RET_HS_CLOCK 4
`define RET_RTC_REG 5
`define RET_SLOW_CLOCK 6
`define RET_THERMAL 7
`define RET_WRITE_MASK 8'hF7

// ----------------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------------
`define CTRL_SLEEP_PERMIT 0
`define CONV_CFG_PWM_LSB 4
`define CONV_CFG_WRITE_MASK 8'h77

// Supply mode override encodings
`define OVR_FOLLOW 2'b00
`define OVR_ON_FULL 2'b01
`define OVR_OFF 2'b10
`define OVR_ON_LOW 2'b11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CONV_CFG 8'h77

`endif

// *** src/two_wire_reg_port.v ***
// Two-wire serial register port: device address, register pointer,
// auto-incrementing byte writes and reads. Assumes a synchronised reset.
module two_wire_reg_port #(
    parameter [6:0] DEV_ADDR = 7'h2D
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_oe_o,
    output reg [7:0] ptr_o,
    output reg [7:0] wdata_o,
    output reg wr_o,
    input wire [7:0] rdata_i
);

// ----------------------------------------------------------------------
// Pin synchronisers, change taken when second and third stage agree
// ----------------------------------------------------------------------
reg [2:0] scl_sync;
reg [2:0] sda_sync;
reg scl_f;
reg sda_f;
reg scl_d;
reg sda_d;
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        scl_sync <= 3'b111;
        sda_sync <= 3'b111;
        scl_f <= 1'b1;
        sda_f <= 1'b1;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_sync <= {scl_sync[1:0], scl_i};
        sda_sync <= {sda_sync[1:0], sda_i};
        if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
        end
        if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
        end
        scl_d <= scl_f;
        sda_d <= sda_f;
    end
end

wire start_seen = scl_f & scl_d & sda_d & ~sda_f;
wire stop_seen = scl_f & scl_d & ~sda_d & sda_f;
wire scl_rise = scl_f & ~scl_d;
wire scl_fall = ~scl_f & scl_d;

// ----------------------------------------------------------------------
// Byte state machine
// ----------------------------------------------------------------------
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_ADDR = 3'd1;
localparam [2:0] S_ADDR_ACK = 3'd2;
localparam [2:0] S_PTR = 3'd3;
localparam [2:0] S_WDATA = 3'd4;
localparam [2:0] S_WACK = 3'd5;
localparam [2:0] S_RDATA = 3'd6;
localparam [2:0] S_RACK = 3'd7;

reg [2:0] state;
reg [7:0] shift;
reg [7:0] rd_shift;
reg [3:0] bitcnt;
reg rw;
reg was_data;

always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state <= S_IDLE;
        shift <= 8'h00;
        rd_shift <= 8'h00;
        bitcnt <= 4'h0;
        rw <= 1'b0;
        was_data <= 1'b0;
        sda_oe_o <= 1'b0;
        ptr_o <= 8'h00;
        wdata_o <= 8'h00;
        wr_o <= 1'b0;
    end else begin
        wr_o <= 1'b0;
        if (was_data && state != S_WACK) begin
            ptr_o <= ptr_o + 8'h01;
            was_data <= 1'b0;
        end
        if (start_seen) begin
            state <= S_ADDR;
            bitcnt <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (stop_seen) begin
            state <= S_IDLE;
            sda_oe_o <= 1'b0;
        end else if (scl_rise) begin
            case (state)
                S_ADDR, S_PTR, S_WDATA: begin
                    shift <= {shift[6:0], sda_f};
                    bitcnt <= bitcnt + 4'h1;
                end
                S_RDATA: begin
                    bitcnt <= bitcnt + 4'h1;
                end
                S_RACK: begin
                    if (sda_f) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                S_ADDR: begin
                    if (bitcnt == 4'h8) begin
                        if (shift[7:1] == DEV_ADDR) begin
                            rw <= shift[0];
                            sda_oe_o <= 1'b1;
                            state <= S_ADDR_ACK;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK, S_RACK: begin
                    bitcnt <= 4'h0;
                    if (rw) begin
                        rd_shift <= rdata_i;
                        sda_oe_o <= ~rdata_i[7];
                        state <= S_RDATA;
                    end else begin
                        sda_oe_o <= 1'b0;
                        state <= S_PTR;
                    end
                end
                S_PTR: begin
                    if (bitcnt == 4'h8) begin
                        ptr_o <= shift;
                        sda_oe_o <= 1'b1;
                        state <= S_WACK;
                    end
                end
                S_WDATA: begin
                    if (bitcnt == 4'h8) begin
                        wdata_o <= shift;
                        wr_o <= 1'b1;
                        was_data <= 1'b1;
                        sda_oe_o <= 1'b1;
                        state <= S_WACK;
                    end
                end
                S_WACK: begin
                    sda_oe_o <= 1'b0;
                    bitcnt <= 4'h0;
                    state <= S_WDATA;
                end
                S_RDATA: begin
                    if (bitcnt == 4'h8) begin
                        sda_oe_o <= 1'b0;
                        ptr_o <= ptr_o + 8'h01;
                        state <= S_RACK;
                    end else begin
                        rd_shift <= {rd_shift[6:0], 1'b0};
                        sda_oe_o <= ~rd_shift[6];
                    end
                end
                default: begin
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // two_wire_reg_port

// *** src/sleep_resource_keep_control.v ***
// Sleep-state resource retention control: regulators, converters, slow
// clock output, fast internal clock and thermal monitor.
// Assumes device state inputs come from logic on sys_clk_i; pins are async.
`include "sleep_keep_defines.vh"

module sleep_resource_keep_control #(
    parameter [6:0] DEV_ADDR = 7'h2D,
    parameter NUM_REG = 8,
    parameter NUM_CONV = 3
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe_o,
    input wire scaling_bus_enable_line_i,
    input wire slow_clock_i,
    input wire sleep_state_i,
    input wire off_state_i,
    output reg [NUM_REG-1:0] reg_on_o,
    output reg [NUM_REG-1:0] reg_full_load_o,
    output reg [NUM_CONV-1:0] conv_on_o,
    output reg [NUM_CONV-1:0] conv_pwm_o,
    output reg rtc_reg_full_load_o,
    output reg hs_clock_run_o,
    output reg thermal_monitor_on_o,
    output reg slow_clock_output_pin_o,
    output reg sleep_permit_bit_o
);

// ----------------------------------------------------------------------
// Reset release and pin synchronisers
// ----------------------------------------------------------------------
reg [1:0] rst_sync;
wire rst_n = rst_sync[1];
always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rst_sync <= 2'b00;
    end else begin
        rst_sync <= {rst_sync[0], 1'b1};
    end
end

reg [2:0] line_sync;
reg [2:0] slow_sync;
reg line_f;
reg slow_f;
always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        line_sync <= 3'b000;
        slow_sync <= 3'b000;
        line_f <= 1'b0;
        slow_f <= 1'b0;
    end else begin
        line_sync <= {line_sync[1:0], scaling_bus_enable_line_i};
        slow_sync <= {slow_sync[1:0], slow_clock_i};
        if (line_sync[1] == line_sync[2]) begin
            line_f <= line_sync[2];
        end
        if (slow_sync[1] == slow_sync[2]) begin
            slow_f <= slow_sync[2];
        end
    end
end

// ----------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------
wire [7:0] ptr;
wire [7:0] wdata;
wire wr;
reg [7:0] rdata;

two_wire_reg_port #(
    .DEV_ADDR(DEV_ADDR)
) u_port (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .ptr_o(ptr),
    .wdata_o(wdata),
    .wr_o(wr),
    .rdata_i(rdata)
);

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [7:0] keep_full_load;
reg [7:0] retention;
reg [7:0] reg_enable;
reg [7:0] reg_assign;
reg [7:0] reg_ovr_lo;
reg [7:0] reg_ovr_hi;
reg [7:0] conv_cfg;
reg [7:0] conv_ovr;

always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        keep_full_load <= `RST_BYTE;
        retention <= `RST_BYTE;
        reg_enable <= `RST_BYTE;
        reg_assign <= `RST_BYTE;
        reg_ovr_lo <= `RST_BYTE;
        reg_ovr_hi <= `RST_BYTE;
        conv_cfg <= `RST_CONV_CFG;
        conv_ovr <= `RST_BYTE;
        sleep_permit_bit_o <= 1'b0;
        sda_o <= 1'b0;
    end else begin
        sda_o <= 1'b0;
        if (off_state_i) begin
            sleep_permit_bit_o <= 1'b0;
        end else if (wr && ptr == `OFS_DEV_CTRL) begin
            sleep_permit_bit_o <= wdata[`CTRL_SLEEP_PERMIT];
        end
        if (wr) begin
            case (ptr)
                `OFS_KEEP_FULL_LOAD: keep_full_load <= wdata;
                `OFS_RETENTION: retention <= wdata & `RET_WRITE_MASK;
                `OFS_REG_ENABLE: reg_enable <= wdata;
                `OFS_REG_ASSIGN: reg_assign <= wdata;
                `OFS_REG_OVR_LO: reg_ovr_lo <= wdata;
                `OFS_REG_OVR_HI: reg_ovr_hi <= wdata;
                `OFS_CONV_CFG: conv_cfg <= wdata & `CONV_CFG_WRITE_MASK;
                `OFS_CONV_OVR: conv_ovr <= wdata;
                default: begin
                end
            endcase
        end
    end
end

always @* begin
    case (ptr)
        `OFS_KEEP_FULL_LOAD: rdata = keep_full_load;
        `OFS_RETENTION: rdata = retention;
        `OFS_DEV_CTRL: rdata = {7'h00, sleep_permit_bit_o};
        `OFS_REG_ENABLE: rdata = reg_enable;
        `OFS_REG_ASSIGN: rdata = reg_assign;
        `OFS_REG_OVR_LO: rdata = reg_ovr_lo;
        `OFS_REG_OVR_HI: rdata = reg_ovr_hi;
        `OFS_CONV_CFG: rdata = conv_cfg;
        `OFS_CONV_OVR: rdata = conv_ovr;
        `OFS_STATUS: rdata = {4'h0, thermal_monitor_on_o, hs_clock_run_o, line_f,
            sleep_state_i};
        default: rdata = 8'h00;
    endcase
end

// ----------------------------------------------------------------------
// Supply state resolution: returns {on, full}
// ----------------------------------------------------------------------
function [1:0] resolve;
    input [1:0] ovr;
    input on;
    input full;
    begin
        case (ovr)
            `OVR_ON_FULL: resolve = 2'b11;
            `OVR_OFF: resolve = 2'b00;
            `OVR_ON_LOW: resolve = 2'b10;
            default: resolve = {on, on & full};
        endcase
    end
endfunction

wire [15:0] reg_ovr = {reg_ovr_hi, reg_ovr_lo};
reg [NUM_REG-1:0] next_reg_on;
reg [NUM_REG-1:0] next_reg_full;
reg [NUM_CONV-1:0] next_conv_on;
reg [NUM_CONV-1:0] next_conv_pwm;
reg [1:0] st;
integer i;

always @* begin
    next_reg_on = {NUM_REG{1'b0}};
    next_reg_full = {NUM_REG{1'b0}};
    next_conv_on = {NUM_CONV{1'b0}};
    next_conv_pwm = {NUM_CONV{1'b0}};
    st = 2'b00;
    for (i = 0; i < NUM_REG; i = i + 1) begin
        if (reg_assign[i] && line_f) begin
            st = 2'b11;
        end else if (reg_assign[i]) begin
            st = resolve(reg_ovr[2*i +: 2], keep_full_load[i], 1'b1);
        end else if (sleep_state_i) begin
            st = resolve(reg_ovr[2*i +: 2], reg_enable[i], keep_full_load[i]);
        end else begin
            st = {reg_enable[i], reg_enable[i]};
        end
        next_reg_on[i] = st[1];
        next_reg_full[i] = st[0];
    end
    for (i = 0; i < NUM_CONV; i = i + 1) begin
        if (sleep_state_i) begin
            st = resolve(conv_ovr[2*i +: 2], conv_cfg[i],
                retention[`RET_CONV_LSB + i] & conv_cfg[`CONV_CFG_PWM_LSB + i]);
        end else begin
            st = {conv_cfg[i], conv_cfg[i] & conv_cfg[`CONV_CFG_PWM_LSB + i]};
        end
        next_conv_on[i] = st[1];
        next_conv_pwm[i] = st[0];
    end
end

// ----------------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------------
always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
        reg_on_o <= {NUM_REG{1'b0}};
        reg_full_load_o <= {NUM_REG{1'b0}};
        conv_on_o <= {NUM_CONV{1'b0}};
        conv_pwm_o <= {NUM_CONV{1'b0}};
        rtc_reg_full_load_o <= 1'b1;
        hs_clock_run_o <= 1'b1;
        thermal_monitor_on_o <= 1'b1;
        slow_clock_output_pin_o <= 1'b0;
    end else begin
        reg_on_o <= next_reg_on;
        reg_full_load_o <= next_reg_full;
        conv_on_o <= next_conv_on;
        conv_pwm_o <= next_conv_pwm;
        rtc_reg_full_load_o <= ~sleep_state_i | retention[`RET_RTC_REG];
        hs_clock_run_o <= ~sleep_state_i | retention[`RET_HS_CLOCK];
        thermal_monitor_on_o <= ~sleep_state_i | retention[`RET_THERMAL];
        slow_clock_output_pin_o <= slow_f &
            (~sleep_state_i | retention[`RET_SLOW_CLOCK]);
    end
end

endmodule // sleep_resource_keep_control

// *** tb/sleep_keep_checker.sv ***
// Port-level assertions for the sleep keep block.
// Assumes the block's one clock domain and its active-low reset.
module sleep_keep_checker #(
    parameter NUM_REG = 8,
    parameter NUM_CONV = 3
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire slow_clock_i,
    input wire sleep_state_i,
    input wire off_state_i,
    input wire [NUM_REG-1:0] reg_on_o,
    input wire [NUM_REG-1:0] reg_full_load_o,
    input wire [NUM_CONV-1:0] conv_on_o,
    input wire [NUM_CONV-1:0] conv_pwm_o,
    input wire rtc_reg_full_load_o,
    input wire hs_clock_run_o,
    input wire thermal_monitor_on_o,
    input wire slow_clock_output_pin_o,
    input wire sleep_permit_bit_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_RST_VALUES: assert property (disable iff (1'b0) !nrst_i && !$past(nrst_i) |->
        reg_on_o == '0 && reg_full_load_o == '0 && conv_pwm_o == '0 && !sleep_permit_bit_o)
        else $error("outputs not at reset values");
    AST_FULL_NEEDS_ON: assert property ((reg_full_load_o & ~reg_on_o) == '0)
        else $error("full load on a regulator that is off");
    AST_AWAKE_PAIR: assert property (!$past(sleep_state_i) |-> reg_on_o == reg_full_load_o)
        else $error("awake regulator not on at full load");
    AST_HS_AWAKE: assert property (!$past(sleep_state_i) |-> hs_clock_run_o)
        else $error("fast clock stopped while awake");
    AST_THERMAL_AWAKE: assert property (sleep_state_i ##1 !sleep_state_i |=> thermal_monitor_on_o)
        else $error("thermal monitor off after wake");
    AST_PERMIT_OFF: assert property (off_state_i |=> !sleep_permit_bit_o)
        else $error("sleep permit kept in off state");
    AST_SLOW_FOLLOW: assert property ($past(nrst_i, 8) && $rose(slow_clock_i) && !sleep_state_i
        |-> ##[2:6] (slow_clock_output_pin_o || sleep_state_i))
        else $error("slow clock output does not follow source");
    AST_CONV_STEADY: assert property (($past(nrst_i, 12) && !sleep_state_i && scl_i) [*8]
        |-> $stable(conv_pwm_o) && $stable(conv_on_o))
        else $error("converter outputs moved without cause");
    cover property ($rose(sleep_state_i));
    cover property (off_state_i);
    cover property (sleep_state_i && slow_clock_output_pin_o);
endmodule // sleep_keep_checker

bind sleep_resource_keep_control sleep_keep_checker #(.NUM_REG(NUM_REG), .NUM_CONV(NUM_CONV))
    sleep_keep_checker_inst (.sys_clk_i, .nrst_i, .scl_i, .slow_clock_i, .sleep_state_i,
    .off_state_i, .reg_on_o, .reg_full_load_o, .conv_on_o, .conv_pwm_o, .rtc_reg_full_load_o,
    .hs_clock_run_o, .thermal_monitor_on_o, .slow_clock_output_pin_o, .sleep_permit_bit_o);

// *** tb/host_bus_master.sv ***
// Host side two-wire master: byte writes and pointer reads.
// Assumes an open-drain data wire resolved by the bench.
module host_bus_master #(
    parameter [6:0] DEV_ADDR = 7'h2D // Arbitrary value
) (
    input wire sys_clk_i,
    input wire sda_line_i,
    output reg scl_o,
    output reg sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 25;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        r = sda_line_i;
        scl_o = 1'b0;
        hold(5);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(last, a);
    endtask
    // Sleep permit and all settings go through here
    task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] wd,
        output logic [7:0] q);
        logic [7:0] t;
        sda_low_o = 1'b1;
        hold(HALF);
        scl_o = 1'b0;
        hold(5);
        byte_io({DEV_ADDR, 1'b0}, 1'b1, t);
        byte_io(ptr, 1'b1, t);
        if (rd) begin
            sda_low_o = 1'b0;
            hold(HALF);
            scl_o = 1'b1;
            hold(HALF);
            sda_low_o = 1'b1;
            hold(HALF);
            scl_o = 1'b0;
            hold(5);
            byte_io({DEV_ADDR, 1'b1}, 1'b1, t);
            byte_io(8'hFF, 1'b1, q);
        end else begin
            byte_io(wd, 1'b1, t);
        end
        sda_low_o = 1'b1;
        hold(HALF);
        scl_o = 1'b1;
        hold(HALF);
        sda_low_o = 1'b0;
        hold(HALF);
    endtask
endmodule // host_bus_master

// *** tb/tb_top.sv ***
// Self-checking bench of the sleep keep block.
// Assumes the host model and the checker bound to the design.
`include "sleep_keep_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, nrst_i, scl, sda_low, scaling_bus_enable_line_i, slow_clock_i;
    logic sleep_state_i, off_state_i;
    wire sda_i, sda_o, sda_oe_o, rtc_reg_full_load_o, hs_clock_run_o, thermal_monitor_on_o;
    wire slow_clock_output_pin_o, sleep_permit_bit_o;
    wire [7:0] reg_on_o, reg_full_load_o;
    wire [2:0] conv_on_o, conv_pwm_o;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    assign sda_i = !(sda_low | sda_oe_o);
    sleep_resource_keep_control sleep_resource_keep_control_inst (.sys_clk_i, .nrst_i,
        .scl_i(scl), .sda_i, .sda_o, .sda_oe_o, .scaling_bus_enable_line_i, .slow_clock_i,
        .sleep_state_i, .off_state_i, .reg_on_o, .reg_full_load_o, .conv_on_o, .conv_pwm_o,
        .rtc_reg_full_load_o, .hs_clock_run_o, .thermal_monitor_on_o, .slow_clock_output_pin_o,
        .sleep_permit_bit_o);
    host_bus_master host_bus_master_inst (.sys_clk_i, .sda_line_i(sda_i), .scl_o(scl),
        .sda_low_o(sda_low));
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always begin
        repeat (40) @(negedge sys_clk_i);
        slow_clock_i = !slow_clock_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_bus_master_inst.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        host_bus_master_inst.xfer(1'b1, a, 8'h00, q);
    endtask
    task automatic go_sleep(input logic s);
        sleep_state_i = s;
        repeat (8) @(negedge sys_clk_i);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] q;
        check({7'h0, sda_o}, 8'h00);
        rd(`OFS_KEEP_FULL_LOAD, q);
        check(q, 8'h00);
        rd(`OFS_RETENTION, q);
        check(q, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_keep;
        wr(`OFS_REG_ENABLE, 8'hFF);
        wr(`OFS_KEEP_FULL_LOAD, 8'hA5);
        check(reg_full_load_o, 8'hFF);
        go_sleep(1'b1);
        check(reg_on_o, 8'hFF);
        check(reg_full_load_o, 8'hA5);
        go_sleep(1'b0);
        wr(`OFS_REG_OVR_LO, 8'h36);
        go_sleep(1'b1);
        check(reg_on_o, 8'hFE);
        check(reg_full_load_o, 8'hA2);
        go_sleep(1'b0);
        wr(`OFS_REG_OVR_LO, 8'h00);
        $display("test keep and override done");
    endtask
    task automatic t_retention;
        logic [7:0] v, q;
        logic seen;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h00 : 8'hFF;
            wr(`OFS_RETENTION, v);
            rd(`OFS_RETENTION, q);
            check(q, v & 8'hF7);
            go_sleep(1'b1);
            check({5'h0, conv_pwm_o}, {5'h0, v[2:0]});
            check({7'h0, rtc_reg_full_load_o}, {7'h0, v[5]});
            check({7'h0, hs_clock_run_o}, {7'h0, v[4]});
            check({7'h0, thermal_monitor_on_o}, {7'h0, v[7]});
            seen = 1'b0;
            repeat (100) begin
                @(negedge sys_clk_i);
                seen |= slow_clock_output_pin_o;
            end
            check({7'h0, seen}, {7'h0, v[6]});
            go_sleep(1'b0);
        end
        wr(`OFS_CONV_CFG, 8'h36);
        wr(`OFS_RETENTION, 8'hFF);
        go_sleep(1'b1);
        check({5'h0, conv_on_o}, 8'h06);
        check({5'h0, conv_pwm_o}, 8'h02);
        go_sleep(1'b0);
        wr(`OFS_CONV_OVR, 8'h01);
        check({5'h0, conv_on_o}, 8'h06);
        go_sleep(1'b1);
        check({5'h0, conv_on_o}, 8'h07);
        check({5'h0, conv_pwm_o}, 8'h03);
        go_sleep(1'b0);
        $display("test retention done");
    endtask
    task automatic t_off_and_line;
        wr(`OFS_REG_ENABLE, 8'h00);
        wr(`OFS_KEEP_FULL_LOAD, 8'hFF);
        go_sleep(1'b1);
        check(reg_on_o, 8'h00);
        go_sleep(1'b0);
        wr(`OFS_REG_ASSIGN, 8'h01);
        wr(`OFS_KEEP_FULL_LOAD, 8'hFE);
        check({6'h0, reg_on_o[0], reg_full_load_o[0]}, 8'h03);
        scaling_bus_enable_line_i = 1'b0;
        go_sleep(1'b0);
        check({7'h0, reg_on_o[0]}, 8'h00);
        wr(`OFS_KEEP_FULL_LOAD, 8'hFF);
        check({6'h0, reg_on_o[0], reg_full_load_o[0]}, 8'h03);
        scaling_bus_enable_line_i = 1'b1;
        $display("test off and scaling line done");
    endtask
    task automatic t_permit;
        logic [7:0] q;
        wr(`OFS_DEV_CTRL, 8'h01);
        check({7'h0, sleep_permit_bit_o}, 8'h01);
        wr(`OFS_DEV_CTRL, 8'h00);
        check({7'h0, sleep_permit_bit_o}, 8'h00);
        wr(`OFS_DEV_CTRL, 8'h01);
        off_state_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        off_state_i = 1'b0;
        check({7'h0, sleep_permit_bit_o}, 8'h00);
        rd(8'h60, q);
        check(q, 8'h00);
        $display("test sleep permit done");
    endtask
    initial begin
        nrst_i = 1'b0;
        sleep_state_i = 1'b0;
        off_state_i = 1'b0;
        scaling_bus_enable_line_i = 1'b1;
        slow_clock_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (12) @(negedge sys_clk_i);
        t_reset();
        t_keep();
        t_retention();
        t_off_and_line();
        t_permit();
        complete_run();
    end
endmodule // tb_top
